// ==== hw/adcc_pkg.sv ====
// adcc_pkg: register map, field positions, reset values and states of the conversion control
package adcc_pkg;

  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 4;
  localparam int RESULT_W = 12;
  localparam int CHAN_W   = 5;

  // register offsets
  localparam logic [3:0] OFS_STATUS_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFS_STATUS_CONTROL_TWO = 4'h1;
  localparam logic [3:0] OFS_RESULT_HIGH        = 4'h2;
  localparam logic [3:0] OFS_RESULT_LOW         = 4'h3;
  localparam logic [3:0] OFS_COMPARE_HIGH       = 4'h4;
  localparam logic [3:0] OFS_COMPARE_LOW        = 4'h5;
  localparam logic [3:0] OFS_IRQ_STATUS         = 4'h6;
  localparam logic [3:0] OFS_IRQ_CLEAR          = 4'h7;
  localparam logic [3:0] OFS_IRQ_ENABLE         = 4'h8;

  // first status/control register fields
  localparam int BIT_DONE_FLAG     = 7;
  localparam int BIT_DONE_IRQ_EN   = 6;
  localparam int BIT_CONTINUOUS    = 5;
  localparam int CHAN_MSB          = 4;

  // second status/control register fields
  localparam int BIT_ACTIVE        = 7;
  localparam int BIT_TRIGGER_SEL   = 6;
  localparam int BIT_COMPARE_EN    = 5;
  localparam int BIT_COMPARE_GE    = 4;

  // interrupt status bits
  localparam int IRQ_BIT_DONE      = 0;
  localparam int IRQ_BIT_ABORT     = 1;
  localparam int IRQ_W             = 2;

  // channel codes
  localparam logic [4:0] CHAN_LAST_EXTERNAL = 5'h1B;
  localparam logic [4:0] CHAN_RESERVED      = 5'h1C;
  localparam logic [4:0] CHAN_HIGH_REF      = 5'h1D;
  localparam logic [4:0] CHAN_LOW_REF       = 5'h1E;
  localparam logic [4:0] CHAN_DISABLED      = 5'h1F;

  // reset values
  localparam logic [4:0]  RST_CHANNEL  = 5'h1F;
  localparam logic [11:0] RST_RESULT   = 12'h000;
  localparam logic [11:0] RST_COMPARE  = 12'h000;
  localparam logic [7:0]  RST_READ     = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b001,
    ST_WAIT_TRIG = 3'b010,
    ST_CONVERT   = 3'b100
  } adcc_state_t;

endpackage

// ==== hw/adcc_cmp_if.sv ====
// adcc_cmp_if: result and compare settings between control and compare unit
`timescale 1ns/1ps
interface adcc_cmp_if #(
  parameter int RESULT_W = 12
);
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] compare_value;
  logic                compare_greater_equal;
  logic                match;

  modport ctrl (output result, output compare_value, output compare_greater_equal, input match);
  modport unit (input result, input compare_value, input compare_greater_equal, output match);
endinterface

// ==== hw/adcc_compare.sv ====
// adcc_compare: evaluates the automatic compare condition for a finished result
`timescale 1ns/1ps
module adcc_compare
  import adcc_pkg::*;
(
  // compare data
  adcc_cmp_if.unit cmp
);

  always_comb begin
    if (cmp.compare_greater_equal) begin
      cmp.match = (cmp.result >= cmp.compare_value);
    end else begin
      cmp.match = (cmp.result < cmp.compare_value);
    end
  end

endmodule

// ==== hw/adcc_trigger_sync.sv ====
// adcc_trigger_sync: three-stage synchroniser and rising-edge pulse for the hardware trigger
`timescale 1ns/1ps
module adcc_trigger_sync
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // trigger
  input  wire logic trigger_async,
  output logic      trigger_pulse
);

  logic stage_one;
  logic stage_two;
  logic stage_three;
  logic level;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_one   <= 1'b0;
      stage_two   <= 1'b0;
      stage_three <= 1'b0;
    end else begin
      stage_one   <= trigger_async;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level         <= 1'b0;
      trigger_pulse <= 1'b0;
    end else begin
      if (stage_two == stage_three) begin
        level <= stage_three;
      end
      trigger_pulse <= (stage_two == stage_three) && stage_three && !level;
    end
  end

endmodule

// ==== hw/adcc_control.sv ====
// adcc_control: register file, trigger handling and sequencing of the successive-approximation converter
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module adcc_control
  import adcc_pkg::*;
#(
  parameter int RES_W = RESULT_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // hardware trigger from the periodic counter
  input  wire logic              hardware_trigger_in,
  // converter core
  output logic                   conv_start,
  output logic                   conv_abort,
  output logic      [CHAN_W-1:0] conv_channel,
  output logic                   converter_power_on,
  output logic                   input_isolate,
  output logic                   high_reference,
  output logic                   low_reference,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result,
  // interrupt
  output logic                   irq
);

  adcc_state_t       state;
  adcc_state_t       next_state;

  logic [CHAN_W-1:0] channel_select;
  logic              continuous_convert_enable;
  logic              done_interrupt_enable;
  logic              conversion_done_flag;
  logic              conversion_active;
  logic              trigger_select;
  logic              compare_enable;
  logic              compare_greater_equal;
  logic [RES_W-1:0]  result;
  logic [RES_W-1:0]  compare_value;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_enable;

  logic              hw_trigger;
  logic              write_one;
  logic              read_low;
  logic              disable_write;
  logic              finish;
  logic              accept;
  logic              start_now;
  logic              abort_now;
  logic [IRQ_W-1:0]  irq_event;
  logic [CHAN_W-1:0] next_channel;
  // decoded write strobes, one per writable register
  logic              write_two;
  logic              write_cmp_high;
  logic              write_cmp_low;
  logic              write_irq_clear;
  logic              write_irq_enable;

  adcc_cmp_if #(.RESULT_W(RES_W)) cmp_bus ();

  // the trigger comes from another clock domain, so it passes the synchroniser first
  adcc_trigger_sync u_trigger_sync (
    .clk           (clk),
    .reset_n       (reset_n),
    .trigger_async (hardware_trigger_in),
    .trigger_pulse (hw_trigger)
  );

  // the compare unit is purely combinational and looks at the live core result
  adcc_compare u_compare (
    .cmp (cmp_bus.unit)
  );

  assign cmp_bus.result                = conv_result;
  assign cmp_bus.compare_value         = compare_value;
  assign cmp_bus.compare_greater_equal = compare_greater_equal;

  // decode of a register address, used by both write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] ofs);
    hit = (addr == ADDR_W'(ofs));
  endfunction

  // codes that leave the analog inputs cut off: disabled, and the reserved code
  function automatic logic isolated_code(input logic [CHAN_W-1:0] chan);
    isolated_code = (chan == CHAN_DISABLED) || (chan == CHAN_RESERVED);
  endfunction

  assign write_one     = reg_write && hit(reg_addr, OFS_STATUS_CONTROL_ONE);
  assign read_low      = reg_read && hit(reg_addr, OFS_RESULT_LOW);
  assign disable_write = write_one && (reg_wdata[CHAN_MSB:0] == CHAN_DISABLED);

  assign write_two        = reg_write && hit(reg_addr, OFS_STATUS_CONTROL_TWO);
  assign write_cmp_high   = reg_write && hit(reg_addr, OFS_COMPARE_HIGH);
  assign write_cmp_low    = reg_write && hit(reg_addr, OFS_COMPARE_LOW);
  assign write_irq_clear  = reg_write && hit(reg_addr, OFS_IRQ_CLEAR);
  assign write_irq_enable = reg_write && hit(reg_addr, OFS_IRQ_ENABLE);

  // the core must see the channel of a write together with the start it causes, not a cycle later
  always_comb begin
    if (write_one) begin
      next_channel = reg_wdata[CHAN_MSB:0];
    end else begin
      next_channel = channel_select;
    end
  end

  // a completion that meets a write to control one is dropped: the write aborts it
  assign finish        = (state == ST_CONVERT) && conv_done && !write_one;
  // a finished result is taken unless compare is on and its condition fails
  assign accept        = finish && (!compare_enable || cmp_bus.match);
  assign abort_now     = write_one && (state == ST_CONVERT);

  // sequencing
  always_comb begin
    next_state = state;
    start_now  = 1'b0;
    if (write_one) begin
      if (disable_write) begin
        next_state = ST_IDLE;
      end else if (!trigger_select) begin
        next_state = ST_CONVERT;
        start_now  = 1'b1;
      end else begin
        next_state = ST_WAIT_TRIG;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_WAIT_TRIG: begin
          if (hw_trigger) begin
            next_state = ST_CONVERT;
            start_now  = 1'b1;
          end
        end
        ST_CONVERT: begin
          // hardware triggers that arrive while converting are dropped, not queued
          if (conv_done) begin
            if (continuous_convert_enable) begin
              next_state = ST_CONVERT;
              start_now  = 1'b1;
            end else if (trigger_select) begin
              next_state = ST_WAIT_TRIG;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // an unknown code falls back to idle through the default branch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // converter core drive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conv_start         <= 1'b0;
      conv_abort         <= 1'b0;
      converter_power_on <= 1'b0;
    end else begin
      conv_start         <= start_now;
      // abort and start come together on a restart; the core lets the start win
      conv_abort         <= abort_now;
      // powered only while converting, low power otherwise
      converter_power_on <= (next_state == ST_CONVERT);
    end
  end

  // channel routing; reserved codes pass through and give whatever the core returns
  // these follow next_channel so they change in the same cycle as conv_start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conv_channel   <= RST_CHANNEL;
      input_isolate  <= 1'b1;
      high_reference <= 1'b0;
      low_reference  <= 1'b0;
    end else begin
      conv_channel   <= next_channel;
      input_isolate  <= isolated_code(next_channel);
      high_reference <= (next_channel == CHAN_HIGH_REF);
      low_reference  <= (next_channel == CHAN_LOW_REF);
    end
  end

  // first status/control register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      channel_select            <= RST_CHANNEL;
      continuous_convert_enable <= 1'b0;
      done_interrupt_enable     <= 1'b0;
    end else if (write_one) begin
      channel_select            <= reg_wdata[CHAN_MSB:0];
      continuous_convert_enable <= reg_wdata[BIT_CONTINUOUS];
      done_interrupt_enable     <= reg_wdata[BIT_DONE_IRQ_EN];
    end
  end

  // done flag: a completion in the same cycle as a low-byte read still sets it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conversion_done_flag <= 1'b0;
    end else if (accept) begin
      conversion_done_flag <= 1'b1;
    end else if (write_one || read_low) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // second status/control register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trigger_select        <= 1'b0;
      compare_enable        <= 1'b0;
      compare_greater_equal <= 1'b0;
    end else if (write_two) begin
      trigger_select        <= reg_wdata[BIT_TRIGGER_SEL];
      compare_enable        <= reg_wdata[BIT_COMPARE_EN];
      compare_greater_equal <= reg_wdata[BIT_COMPARE_GE];
    end
  end

  // follows the next state, so an abort-and-restart keeps it high without a gap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conversion_active <= 1'b0;
    end else begin
      conversion_active <= (next_state == ST_CONVERT);
    end
  end

  // compare value, split into high nibble and low byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      compare_value <= RST_COMPARE;
    end else if (write_cmp_high) begin
      compare_value[RES_W-1:DATA_W] <= reg_wdata[RES_W-DATA_W-1:0];
    end else if (write_cmp_low) begin
      compare_value[DATA_W-1:0] <= reg_wdata;
    end
  end

  // stored raw; no difference against the compare value is formed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result <= RST_RESULT;
    end else if (accept) begin
      result <= conv_result;
    end
  end

  // interrupt status: events are sticky, set beats clear
  assign irq_event[IRQ_BIT_DONE]  = accept && done_interrupt_enable;
  // an abort is reported even while the done interrupt is disabled
  assign irq_event[IRQ_BIT_ABORT] = abort_now;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else if (write_irq_clear) begin
      irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // same layout as the status register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_enable <= '0;
    end else if (write_irq_enable) begin
      irq_enable <= reg_wdata[IRQ_W-1:0];
    end
  end

  // registered, so the line follows the status by one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // read data in the cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= RST_READ;
    end else if (!reg_read) begin
      reg_rdata <= RST_READ;
    end else if (hit(reg_addr, OFS_STATUS_CONTROL_ONE)) begin
      reg_rdata <= {conversion_done_flag, done_interrupt_enable, continuous_convert_enable, channel_select};
    end else if (hit(reg_addr, OFS_STATUS_CONTROL_TWO)) begin
      reg_rdata <= {conversion_active, trigger_select, compare_enable, compare_greater_equal, 4'h0};
    end else if (hit(reg_addr, OFS_RESULT_HIGH)) begin
      reg_rdata <= {4'h0, result[RES_W-1:DATA_W]};
    end else if (hit(reg_addr, OFS_RESULT_LOW)) begin
      reg_rdata <= result[DATA_W-1:0];
    end else if (hit(reg_addr, OFS_COMPARE_HIGH)) begin
      reg_rdata <= {4'h0, compare_value[RES_W-1:DATA_W]};
    end else if (hit(reg_addr, OFS_COMPARE_LOW)) begin
      reg_rdata <= compare_value[DATA_W-1:0];
    end else if (hit(reg_addr, OFS_IRQ_STATUS)) begin
      reg_rdata <= {6'h00, irq_status};
    end else if (hit(reg_addr, OFS_IRQ_ENABLE)) begin
      reg_rdata <= {6'h00, irq_enable};
    end else begin
      reg_rdata <= RST_READ;
    end
  end

endmodule

// ==== sim/adcc_core_model.sv ====
// adcc_core_model: behavioural converter core and periodic trigger source
`timescale 1ns/1ps
module adcc_core_model
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // converter requests
  input  wire logic                conv_start,
  input  wire logic                conv_abort,
  input  wire logic [7:0]          conv_cycles,
  input  wire logic [RESULT_W-1:0] next_result,
  output logic                     conv_done,
  output logic      [RESULT_W-1:0] conv_result,
  // periodic trigger
  input  wire logic                trigger_run,
  output logic                     hardware_trigger_in
);
  logic [7:0] remain;
  logic [5:0] period;

  // outside the done cycle the result lines show the inverse, so a late sample is caught
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    conv_result <= ~next_result;
    if (!reset_n) begin
      remain <= 8'h00;
    end else if (conv_start) begin
      remain <= conv_cycles;
    end else if (conv_abort) begin
      remain <= 8'h00;
    end else if (remain == 8'h01) begin
      remain <= 8'h00;
      conv_done <= 1'b1;
      conv_result <= next_result;
    end else if (remain != 8'h00) begin
      remain <= remain - 8'h01;
    end
  end

  // overflow pulse held four cycles so the synchroniser cannot miss it
  always_ff @(posedge clk) begin
    if (!trigger_run || period == 6'h27) period <= 6'h00;
    else period <= period + 6'h01;
    hardware_trigger_in <= trigger_run && period >= 6'h24;
  end
endmodule

// ==== sim/adcc_control_properties.sv ====
// adcc_control_properties: port-level assertions for the conversion control
`timescale 1ns/1ps
module adcc_control_checker
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  // converter core
  input wire logic              conv_start,
  input wire logic [CHAN_W-1:0] conv_channel,
  input wire logic              converter_power_on,
  input wire logic              input_isolate,
  input wire logic              high_reference,
  input wire logic              low_reference,
  input wire logic              conv_done
);
  logic              sc1_wr;
  logic              trig_sel;
  logic              cont;
  logic [CHAN_W-1:0] wchan;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  assign sc1_wr = reg_write && reg_addr == OFS_STATUS_CONTROL_ONE;
  // shadows of the control bits that decide what a write or a completion must do
  always_ff @(posedge clk) begin
    if (!reset_n) trig_sel <= 1'b0;
    else if (reg_write && reg_addr == OFS_STATUS_CONTROL_TWO) trig_sel <= reg_wdata[BIT_TRIGGER_SEL];
  end
  always_ff @(posedge clk) begin
    if (!reset_n) cont <= 1'b0;
    else if (sc1_wr) cont <= reg_wdata[BIT_CONTINUOUS];
  end
  always_ff @(posedge clk) begin
    wchan <= reg_wdata[CHAN_MSB:0];
  end

  property p_start; sc1_wr && reg_wdata[CHAN_MSB:0] != CHAN_DISABLED && !trig_sel |=> conv_start; endproperty
  a_start: assert property (p_start) else $error("write did not start a conversion");
  property p_off; sc1_wr && reg_wdata[CHAN_MSB:0] == CHAN_DISABLED |=> !conv_start && !converter_power_on; endproperty
  a_off: assert property (p_off) else $error("disabled channel still converting");
  property p_chan; sc1_wr |=> conv_channel == wchan; endproperty
  a_chan: assert property (p_chan) else $error("channel not taken from write");
  property p_refs; high_reference == (conv_channel == CHAN_HIGH_REF) && low_reference == (conv_channel == CHAN_LOW_REF); endproperty
  a_refs: assert property (p_refs) else $error("reference select wrong");
  property p_isolate; input_isolate == (conv_channel == CHAN_DISABLED || conv_channel == CHAN_RESERVED); endproperty
  a_isolate: assert property (p_isolate) else $error("input isolation wrong");
  property p_single; conv_done && converter_power_on && !cont && !reg_write |=> !converter_power_on; endproperty
  a_single: assert property (p_single) else $error("power stayed on after single conversion");
  property p_cont; conv_done && converter_power_on && cont && !reg_write |=> conv_start; endproperty
  a_cont: assert property (p_cont) else $error("continuous mode did not restart");
  property p_active; reg_read && reg_addr == OFS_STATUS_CONTROL_TWO |=> reg_rdata[BIT_ACTIVE] == $past(converter_power_on); endproperty
  a_active: assert property (p_active) else $error("active bit disagrees with conversion");

  c_start: cover property (sc1_wr ##1 conv_start);
  c_cont: cover property (conv_done && cont);
  c_hw: cover property (trig_sel && conv_start);
endmodule

bind adcc_control adcc_control_checker u_checker (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .conv_start, .conv_channel, .converter_power_on, .input_isolate, .high_reference, .low_reference,
  .conv_done);

// ==== sim/adcc_control_tb.sv ====
// adcc_control_tb: self-checking bench for the conversion control
`timescale 1ns/1ps
module adcc_control_tb
  import adcc_pkg::*;
;
  localparam logic [3:0] SC1 = OFS_STATUS_CONTROL_ONE;
  localparam logic [3:0] SC2 = OFS_STATUS_CONTROL_TWO;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [3:0]        reg_addr = 4'h0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [7:0]        reg_rdata;
  logic              hardware_trigger_in;
  logic              conv_start;
  logic              conv_abort;
  logic [4:0]        conv_channel;
  logic              converter_power_on;
  logic              input_isolate;
  logic              high_reference;
  logic              low_reference;
  logic              conv_done;
  logic [11:0]       conv_result;
  logic              irq;
  logic [7:0]        conv_cycles = 8'h06;
  logic [11:0]       next_result = 12'h123;
  logic [11:0]       stored = 12'h123;
  logic              trigger_run = 1'b0;
  int                n_fail = 0;
  int                n_checks = 0;
  int                n;

  always #10 clk = ~clk;

  adcc_control u_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .hardware_trigger_in, .conv_start, .conv_abort, .conv_channel, .converter_power_on, .input_isolate,
    .high_reference, .low_reference, .conv_done, .conv_result, .irq);
  adcc_core_model u_core (.clk, .reset_n, .conv_start, .conv_abort, .conv_cycles, .next_result, .conv_done,
    .conv_result, .trigger_run, .hardware_trigger_in);

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic starts(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1) n++;
    end
  endtask
  // bounded wait for the converter to fall idle, then room for the irq lag
  task automatic wait_idle;
    n = 0;
    while (converter_power_on !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_single;
    rd(SC1, 8'h1F);
    rd(SC2, 8'h00);
    rd(4'hF, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(SC1, 8'h45);
    check(conv_start, 1);
    check(conv_channel, 5'h05);
    rd(SC2, 8'h80);
    wait_idle;
    check(irq, 1);
    rd(SC1, 8'hC5);
    rd(SC2, 8'h00);
    check(converter_power_on, 0);
    rd(OFS_RESULT_HIGH, 8'h01);
    rd(OFS_RESULT_LOW, 8'h23);
    rd(SC1, 8'h45);
    wr(OFS_IRQ_CLEAR, 8'h01);
    @(posedge clk);
    #1;
    check(irq, 0);
  endtask
  task automatic t_masked;
    wr(SC1, 8'h05);
    wait_idle;
    check(irq, 0);
    rd(SC1, 8'h85);
    wr(SC1, 8'h1F);
    check(conv_start, 0);
    rd(SC1, 8'h1F);
  endtask
  task automatic t_compare;
    logic [11:0] res;
    logic        acc;
    wr(OFS_COMPARE_HIGH, 8'h01);
    wr(OFS_COMPARE_LOW, 8'h00);
    rd(OFS_COMPARE_HIGH, 8'h01);
    rd(OFS_COMPARE_LOW, 8'h00);
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 2; k++) begin
        res = k ? 12'h100 : 12'h0FF;
        acc = g ? res >= 12'h100 : res < 12'h100;
        if (acc) stored = res;
        wr(SC2, {3'b001, g[0], 4'h0});
        next_result <= res;
        wr(SC1, 8'h05);
        wait_idle;
        rd(SC1, {acc, 7'h05});
        rd(OFS_RESULT_LOW, stored[7:0]);
      end
    end
    wr(SC2, 8'h00);
  endtask
  task automatic t_cont;
    wr(SC1, 8'h25);
    starts(40);
    check(n > 3, 1);
    wr(SC1, 8'h1F);
    starts(20);
    check(n, 0);
    check(converter_power_on, 0);
  endtask
  task automatic t_abort;
    conv_cycles <= 8'h1E;
    wr(SC1, 8'h05);
    repeat (3) @(posedge clk);
    wr(SC1, 8'h06);
    check(conv_abort, 1);
    check(conv_start, 1);
    check(conv_channel, 5'h06);
    rd(OFS_IRQ_STATUS, 8'h02);
    rd(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_IRQ_CLEAR, 8'h02);
    rd(OFS_IRQ_STATUS, 8'h00);
    check(irq, 0);
    wait_idle;
    conv_cycles <= 8'h06;
  endtask
  task automatic t_hw;
    wr(SC2, 8'h40);
    wr(SC1, 8'h07);
    starts(10);
    check(n, 0);
    trigger_run <= 1'b1;
    n = 0;
    while (conv_start !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(conv_start, 1);
    starts(30);
    check(n, 0);
    starts(20);
    check(n, 1);
    trigger_run <= 1'b0;
    wait_idle;
    wr(SC2, 8'h00);
  endtask
  task automatic t_chan;
    logic [4:0] c;
    for (int i = 0; i < 5; i++) begin
      c = 5'h1B + i[4:0];
      wr(SC1, {3'b000, c});
      check(input_isolate, c == CHAN_RESERVED || c == CHAN_DISABLED);
      check(high_reference, c == 5'h1D);
      check(low_reference, c == 5'h1E);
      wait_idle;
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_single;
    t_masked;
    t_compare;
    t_cont;
    t_abort;
    t_hw;
    t_chan;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule
